// >>> src/irq_pkg.sv
// Shared constants and types for the interrupt controller
package irq_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Register map (byte offsets on APB) and register indices
   localparam logic [7:0] OFS_EDGE     = 8'h00;
   localparam logic [7:0] OFS_PROT     = 8'h04;
   localparam logic [7:0] OFS_PINS     = 8'h08;
   localparam logic [7:0] OFS_TBLV     = 8'h0c;
   localparam logic [7:0] OFS_ADTB     = 8'h10;
   localparam logic [7:0] OFS_GRP0     = 8'h14;
   localparam logic [7:0] OFS_GRP1     = 8'h18;
   localparam logic [7:0] OFS_GRP2     = 8'h1c;

   localparam int         NREG         = 8;
   localparam int         REG_EDGE     = 0;
   localparam int         REG_PROT     = 1;
   localparam int         REG_PINS     = 2;
   localparam int         REG_TBLV     = 3;
   localparam int         REG_ADTB     = 4;
   localparam int         REG_GRP0     = 5;
   localparam int         REG_GRP1     = 6;
   localparam int         REG_GRP2     = 7;

   localparam logic [7:0] REG_RST      = 8'h00;

   // Implemented bits per register; everything else reads zero
   localparam logic [7:0] REG_MASK [NREG] = '{8'h0f, 8'h7f, 8'hff, 8'hff,
                                              8'h33, 8'h33, 8'h33, 8'h77};
   // Request flag bits per register, used for wake-up detection
   localparam logic [7:0] FLAG_MASK [NREG] = '{8'h00, 8'h70, 8'hf0, 8'hf0,
                                               8'h30, 8'h30, 8'h30, 8'h70};

   ////////////////////////////////////////////////////////////////////////////
   // Field positions
   localparam int BIT_PIN0_SEL  = 0;   // Two bits, 1:0
   localparam int BIT_PIN1_SEL  = 2;   // Two bits, 3:2
   localparam int SEL_RISE      = 0;
   localparam int SEL_FALL      = 1;

   localparam int BIT_OVP_F     = 6;
   localparam int BIT_OCP1_F    = 5;
   localparam int BIT_OCP0_F    = 4;
   localparam int BIT_OVP_E     = 3;
   localparam int BIT_OCP1_E    = 2;
   localparam int BIT_OCP0_E    = 1;
   localparam int BIT_EMI       = 0;

   localparam int BIT_G0_F      = 7;
   localparam int BIT_PIN1_F    = 6;
   localparam int BIT_PIN0_F    = 5;
   localparam int BIT_UVP_F     = 4;
   localparam int BIT_G0_E      = 3;
   localparam int BIT_PIN1_E    = 2;
   localparam int BIT_PIN0_E    = 1;
   localparam int BIT_UVP_E     = 0;

   localparam int BIT_TICK0_F   = 7;
   localparam int BIT_LVD_F     = 6;
   localparam int BIT_G2_F      = 5;
   localparam int BIT_G1_F      = 4;
   localparam int BIT_TICK0_E   = 3;
   localparam int BIT_LVD_E     = 2;
   localparam int BIT_G2_E      = 1;
   localparam int BIT_G1_E      = 0;

   localparam int BIT_CONV_F    = 5;
   localparam int BIT_TICK1_F   = 4;
   localparam int BIT_CONV_E    = 1;
   localparam int BIT_TICK1_E   = 0;

   localparam int BIT_CMPA_F    = 5;
   localparam int BIT_CMPP_F    = 4;
   localparam int BIT_CMPA_E    = 1;
   localparam int BIT_CMPP_E    = 0;
   localparam int BIT_NV_F      = 6;
   localparam int BIT_NV_E      = 2;

   ////////////////////////////////////////////////////////////////////////////
   // Vectored sources, index 0 has the highest priority
   localparam int NSRC          = 13;
   localparam int SRC_W         = 4;
   localparam int SRC_REG  [NSRC] = '{REG_PINS, REG_PINS, REG_PROT, REG_PROT, REG_PROT,
                                      REG_PINS, REG_PINS, REG_TBLV, REG_TBLV, REG_ADTB,
                                      REG_TBLV, REG_ADTB, REG_TBLV};
   localparam int SRC_FLAG [NSRC] = '{BIT_PIN0_F, BIT_PIN1_F, BIT_OCP0_F, BIT_OCP1_F,
                                      BIT_OVP_F, BIT_UVP_F, BIT_G0_F, BIT_G1_F, BIT_G2_F,
                                      BIT_CONV_F, BIT_TICK0_F, BIT_TICK1_F, BIT_LVD_F};
   localparam int SRC_EN   [NSRC] = '{BIT_PIN0_E, BIT_PIN1_E, BIT_OCP0_E, BIT_OCP1_E,
                                      BIT_OVP_E, BIT_UVP_E, BIT_G0_E, BIT_G1_E, BIT_G2_E,
                                      BIT_CONV_E, BIT_TICK0_E, BIT_TICK1_E, BIT_LVD_E};

   ////////////////////////////////////////////////////////////////////////////
   // Program counter, return stack and vectors
   localparam int               PC_W        = 12;
   localparam int               STACK_DEPTH = 4;
   localparam int               SP_W        = 3;
   localparam logic [SP_W-1:0]  SP_FULL     = 3'h4;
   localparam logic [PC_W-1:0]  VEC_BASE    = 12'h004;
   localparam logic [PC_W-1:0]  VEC_STEP    = 12'h004;

   typedef enum {ST_IDLE, ST_SETTLE} ctl_state_t;

endpackage

// >>> src/edge_sel_if.sv
// Carrier between the controller and its external pin edge detector
`timescale 1ns/1ps
interface edge_sel_if;
   logic [1:0] pin;
   logic [3:0] sel;
   logic [1:0] hit;

   modport detector (input pin, input sel, output hit);
   modport owner    (output pin, output sel, input hit);
endinterface

// >>> src/pin_edge_detect.sv
// Edge detector for the two external request pins
`timescale 1ns/1ps
module pin_edge_detect
   import irq_pkg::*;
(
   input wire logic        clk_sys,
   input wire logic        rst,
   edge_sel_if.detector    eif
);

   logic [1:0] prev_q;

   // Previous level tracks the pin even in reset, so a pin held high
   // at release is not mistaken for a rising edge
   always_ff @(posedge clk_sys) begin
      prev_q <= eif.pin;
   end

   for (genvar i = 0; i < 2; i++) begin : g_pin
      logic rise;
      logic fall;
      assign rise      = eif.pin[i] & ~prev_q[i];
      assign fall      = ~eif.pin[i] & prev_q[i];
      // Select 00 blocks both edges, 11 passes both
      assign eif.hit[i] = (eif.sel[2*i+SEL_RISE] & rise)
                        | (eif.sel[2*i+SEL_FALL] & fall);
   end

endmodule

// >>> src/irq_controller.sv
// Interrupt controller: request flags, enables, priority, vectoring, return stack
// Notes on behaviour
// - Pin 1 edge select in bits 3:2
// - Pin 0 edge select in bits 1:0
// - Global enable bit 0 gates every vector
// - Events set flags regardless of enable
// - Disabled pending flag never vectors
// - Taking pushes next address, loads vector
// - Return pops saved address back
// - Protection register flag and enable layout
// - Pins and undervolt register layout
// - Tick, lowvolt, group flags register layout
// - Conversion and tick 1 register layout
// - Timer 0 group register layout
// - Timer 1 group register layout
// - Timer 2 and nvdata group layout
// - Unimplemented bits read zero
// - Accept pin and internal sources
// - Group flag set by members, service clears
// - Service clears global enable, flags still record
// - Full stack blocks acknowledgement
// - Newly set flag wakes sleeping core
//
// Register access over APB and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
module irq_controller
   import irq_pkg::*;
(
   input  wire logic             clk_sys,
   input  wire logic             rst,
   input  wire logic             psel,
   input  wire logic             penable,
   input  wire logic             pwrite,
   input  wire logic [7:0]       paddr,
   input  wire logic [31:0]      pwdata,
   output wire logic [31:0]      prdata,
   output wire logic             pready,
   output wire logic             pslverr,
   input  wire logic             ext_request_pin_0,
   input  wire logic             ext_request_pin_1,
   input  wire logic             overvolt_evt,
   input  wire logic             undervolt_evt,
   input  wire logic [1:0]       overcurrent_evt,
   input  wire logic             conv_done_evt,
   input  wire logic [1:0]       tick_evt,
   input  wire logic             lowvolt_evt,
   input  wire logic             nvdata_evt,
   input  wire logic [2:0]       timer_cmpa_evt,
   input  wire logic [2:0]       timer_cmpp_evt,
   input  wire logic [PC_W-1:0]  pc_next,
   input  wire logic             return_from_service,
   input  wire logic             sleeping,
   output wire logic             pc_load,
   output wire logic [PC_W-1:0]  pc_value,
   output wire logic             wake,
   output wire logic [SP_W-1:0]  stack_level
);

   function automatic logic [SRC_W-1:0] first_src(input logic [NSRC-1:0] req);
      first_src = '0;
      for (int k = NSRC - 1; k >= 0; k--) begin
         if (req[k]) begin
            first_src = SRC_W'(k);
         end
      end
   endfunction

   function automatic logic [PC_W-1:0] vec_addr(input logic [SRC_W-1:0] src);
      vec_addr = VEC_BASE + PC_W'(src) * VEC_STEP;
   endfunction

   logic [7:0]       regs_q [NREG];
   logic [7:0]       regs_d [NREG];
   logic [7:0]       set_v  [NREG];
   logic [7:0]       clr_v  [NREG];
   logic [NREG-1:0]  new_set;
   logic [NSRC-1:0]  pend;
   logic [PC_W-1:0]  stack_q [STACK_DEPTH];
   logic [SP_W-1:0]  sp_q;
   logic [31:0]      prdata_q;
   logic             pready_q;
   logic             pslverr_q;
   logic             pc_load_q;
   logic [PC_W-1:0]  pc_value_q;
   logic             wake_q;
   ctl_state_t       state_q;
   edge_sel_if       eif ();

   ////////////////////////////////////////////////////////////////////////////
   // APB slave: one wait state, the access answers on its second cycle

   wire             access   = psel & penable;
   wire             done     = access & pready_q;
   wire             addr_ok  = (paddr[1:0] == 2'b00) && (paddr <= OFS_GRP2);
   wire [2:0]       idx      = paddr[4:2];
   wire             wr_en    = done & pwrite & addr_ok;
   wire [7:0]       rd_byte  = regs_q[idx];

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         pready_q  <= 1'b0;
         prdata_q  <= 32'h0000_0000;
         pslverr_q <= 1'b0;
      end else begin
         pready_q  <= access & ~pready_q;
         prdata_q  <= (access & ~pready_q & addr_ok & ~pwrite) ? {24'h00_0000, rd_byte}
                                                                : 32'h0000_0000;
         pslverr_q <= access & ~pready_q & ~addr_ok;
      end
   end

   assign prdata  = prdata_q;
   assign pready  = pready_q;
   assign pslverr = pslverr_q;

   ////////////////////////////////////////////////////////////////////////////
   // External pins

   assign eif.pin = {ext_request_pin_1, ext_request_pin_0};
   assign eif.sel = regs_q[REG_EDGE][3:0];

   pin_edge_detect u_edges (
      .clk_sys (clk_sys),
      .rst     (rst),
      .eif     (eif)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Arbitration

   // A return in the same cycle holds off a grant, so push and pop never share the pointer
   // Lowest source index wins; the settle state keeps grants two cycles apart
   wire              global_irq_enable        = regs_q[REG_PROT][BIT_EMI];
   wire              stack_full = (sp_q == SP_FULL);
   wire [SRC_W-1:0]  take_src   = first_src(pend);
   wire              take       = (state_q == ST_IDLE) & global_irq_enable & (|pend) & ~stack_full
                                  & ~return_from_service;
   wire              return_from_service_ok    = return_from_service & (sp_q != '0);

   for (genvar k = 0; k < NSRC; k++) begin : g_pend
      assign pend[k] = regs_q[SRC_REG[k]][SRC_FLAG[k]]
                     & regs_q[SRC_REG[k]][SRC_EN[k]];
   end

   // Members only feed their group when their own enable is set
   wire [2:0] grp_hit;
   assign grp_hit[0] = (timer_cmpa_evt[0] & regs_q[REG_GRP0][BIT_CMPA_E])
                     | (timer_cmpp_evt[0] & regs_q[REG_GRP0][BIT_CMPP_E]);
   assign grp_hit[1] = (timer_cmpa_evt[1] & regs_q[REG_GRP1][BIT_CMPA_E])
                     | (timer_cmpp_evt[1] & regs_q[REG_GRP1][BIT_CMPP_E]);
   assign grp_hit[2] = (timer_cmpa_evt[2] & regs_q[REG_GRP2][BIT_CMPA_E])
                     | (timer_cmpp_evt[2] & regs_q[REG_GRP2][BIT_CMPP_E])
                     | (nvdata_evt & regs_q[REG_GRP2][BIT_NV_E]);

   ////////////////////////////////////////////////////////////////////////////
   // Hardware set and clear terms

   always_comb begin
      for (int r = 0; r < NREG; r++) begin
         set_v[r] = 8'h00;
      end
      set_v[REG_PROT][BIT_OVP_F]   = overvolt_evt;
      set_v[REG_PROT][BIT_OCP1_F]  = overcurrent_evt[1];
      set_v[REG_PROT][BIT_OCP0_F]  = overcurrent_evt[0];
      set_v[REG_PROT][BIT_EMI]     = return_from_service_ok;
      set_v[REG_PINS][BIT_G0_F]    = grp_hit[0];
      set_v[REG_PINS][BIT_PIN1_F]  = eif.hit[1];
      set_v[REG_PINS][BIT_PIN0_F]  = eif.hit[0];
      set_v[REG_PINS][BIT_UVP_F]   = undervolt_evt;
      set_v[REG_TBLV][BIT_TICK0_F] = tick_evt[0];
      set_v[REG_TBLV][BIT_LVD_F]   = lowvolt_evt;
      set_v[REG_TBLV][BIT_G2_F]    = grp_hit[2];
      set_v[REG_TBLV][BIT_G1_F]    = grp_hit[1];
      set_v[REG_ADTB][BIT_CONV_F]  = conv_done_evt;
      set_v[REG_ADTB][BIT_TICK1_F] = tick_evt[1];
      set_v[REG_GRP0][BIT_CMPA_F]  = timer_cmpa_evt[0];
      set_v[REG_GRP0][BIT_CMPP_F]  = timer_cmpp_evt[0];
      set_v[REG_GRP1][BIT_CMPA_F]  = timer_cmpa_evt[1];
      set_v[REG_GRP1][BIT_CMPP_F]  = timer_cmpp_evt[1];
      set_v[REG_GRP2][BIT_NV_F]    = nvdata_evt;
      set_v[REG_GRP2][BIT_CMPA_F]  = timer_cmpa_evt[2];
      set_v[REG_GRP2][BIT_CMPP_F]  = timer_cmpp_evt[2];
   end

   // Service clears only the vectored flag; group members stay for software
   always_comb begin
      for (int r = 0; r < NREG; r++) begin
         clr_v[r] = 8'h00;
      end
      clr_v[SRC_REG[take_src]][SRC_FLAG[take_src]] = take;
      clr_v[REG_PROT][BIT_EMI] = take;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Register file: a hardware set wins over any clear in the same cycle

   for (genvar r = 0; r < NREG; r++) begin : g_reg
      wire wr_here = wr_en && (idx == 3'(r));
      assign regs_d[r]  = (((wr_here ? (pwdata[7:0] & REG_MASK[r]) : regs_q[r])
                          & ~clr_v[r]) | set_v[r]);
      assign new_set[r] = |(set_v[r] & FLAG_MASK[r] & ~regs_q[r]);

      always_ff @(posedge clk_sys) begin
         if (rst) begin
            regs_q[r] <= REG_RST;
         end else begin
            regs_q[r] <= regs_d[r];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Return stack and program counter redirection

   for (genvar s = 0; s < STACK_DEPTH; s++) begin : g_stack
      always_ff @(posedge clk_sys) begin
         if (rst) begin
            stack_q[s] <= '0;
         end else if (take && sp_q == SP_W'(s)) begin
            stack_q[s] <= pc_next;
         end
      end
   end

   wire [SP_W-1:0] sp_top = sp_q - 3'h1;

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         sp_q       <= '0;
         pc_load_q  <= 1'b0;
         pc_value_q <= '0;
      end else begin
         pc_load_q <= take | return_from_service_ok;
         if (take) begin
            sp_q       <= sp_q + 3'h1;
            pc_value_q <= vec_addr(take_src);
         end else if (return_from_service_ok) begin
            sp_q       <= sp_top;
            pc_value_q <= stack_q[sp_top[1:0]];
         end
      end
   end

   // The settle cycle lets the cleared flag land before the next grant
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         state_q <= ST_IDLE;
      end else begin
         case (state_q)
            ST_IDLE:   state_q <= take ? ST_SETTLE : ST_IDLE;
            ST_SETTLE: state_q <= ST_IDLE;
            default:   state_q <= ST_IDLE;
         endcase
      end
   end

   // Only a flag going from clear to set wakes; one set before sleep does not
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         wake_q <= 1'b0;
      end else begin
         wake_q <= sleeping & (|new_set);
      end
   end

   assign pc_load     = pc_load_q;
   assign pc_value    = pc_value_q;
   assign wake        = wake_q;
   assign stack_level = sp_q;

   ////////////////////////////////////////////////////////////////////////////
   // Assertions

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);

   a_pin0_rise_flag: assert property (
      (regs_q[REG_EDGE][1:0] == 2'b01) && ext_request_pin_0 && !eif.pin[1] && !take
      && $past(ext_request_pin_0) == 1'b0 && !$past(rst)
      |=> regs_q[REG_PINS][BIT_PIN0_F])
      else $error("pin 0 rising edge did not set its flag");

   a_pin1_off_none: assert property (
      (regs_q[REG_EDGE][3:2] == 2'b00) |-> !eif.hit[1])
      else $error("pin 1 edge seen while disabled");

   a_emi_gates_take: assert property (
      !global_irq_enable |-> !take)
      else $error("vector taken with global enable clear");

   a_flag_any_enable: assert property (
      conv_done_evt |=> regs_q[REG_ADTB][BIT_CONV_F])
      else $error("conversion event did not set its flag");

   a_set_wins_clear: assert property (
      take && take_src == SRC_W'(4) && overvolt_evt |=> regs_q[REG_PROT][BIT_OVP_F])
      else $error("overvoltage event lost to its service clear");

   a_take_enabled_src: assert property (
      take |-> regs_q[SRC_REG[take_src]][SRC_EN[take_src]])
      else $error("vector taken for a disabled source");

   a_take_push_load: assert property (
      take |=> pc_load_q && pc_value_q == vec_addr($past(take_src))
               && sp_q == $past(sp_q) + 3'h1 && stack_q[$past(sp_q[1:0])] == $past(pc_next))
      else $error("take did not push and load the vector");

   a_return_from_service_pop: assert property (
      return_from_service_ok |=> pc_load_q && pc_value_q == $past(stack_q[sp_top[1:0]])
                  && sp_q == $past(sp_top))
      else $error("return did not restore the saved address");

   a_unused_read_zero: assert property (
      pready_q |-> prdata_q[31:8] == 24'h00_0000 && (prdata_q[7:0] & ~REG_MASK[idx]) == 8'h00)
      else $error("unimplemented bits read nonzero");

   a_group_clr_only: assert property (
      take && take_src == SRC_W'(6) && !grp_hit[0] && !timer_cmpa_evt[0]
      && !timer_cmpp_evt[0] && !wr_en
      |=> !regs_q[REG_PINS][BIT_G0_F] && regs_q[REG_GRP0] == $past(regs_q[REG_GRP0]))
      else $error("group service touched member flags or kept group flag");

   a_emi_cleared: assert property (
      take && !return_from_service_ok |=> !global_irq_enable ##1 !take)
      else $error("global enable not cleared on service");

   a_full_no_take: assert property (
      stack_full |-> !take)
      else $error("request acknowledged with full stack");

   a_wake_on_set: assert property (
      sleeping && overvolt_evt && !regs_q[REG_PROT][BIT_OVP_F] |=> wake_q)
      else $error("new flag did not wake the core");

   a_one_at_time: assert property (
      take |=> !take)
      else $error("two vectors taken back to back");

   c_take_pin:    cover property (take && take_src == SRC_W'(0));
   c_stack_full:  cover property (stack_full && (|pend) && global_irq_enable);
   c_return_from_service:        cover property (return_from_service_ok ##1 pc_load_q);
   c_wake:        cover property (wake_q);
   c_group_take:  cover property (take && take_src == SRC_W'(6));

endmodule

// >>> tb/core_model.sv
// Behavioural core: follows vector and return loads, returns on request
`timescale 1ns/1ps
module core_model
   import irq_pkg::*;
#(
   parameter int RET_DELAY = 2
)
(
   input  wire logic            clk_sys,
   input  wire logic            rst,
   input  wire logic            pc_load,
   input  wire logic [PC_W-1:0] pc_value,
   input  wire logic            ret_req,
   output logic      [PC_W-1:0] pc_next,
   output logic                 return_from_service
);
   int wait_q;

   // The core stalls between loads, so the pushed address is predictable
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         pc_next <= 12'h100;
         return_from_service <= 1'b0;
         wait_q <= 0;
      end else begin
         return_from_service <= (wait_q == 1);
         if (ret_req) begin
            wait_q <= RET_DELAY;
         end else if (wait_q > 0) begin
            wait_q <= wait_q - 1;
         end
         if (pc_load) begin
            pc_next <= pc_value + 12'h001;
         end
      end
   end
endmodule

// >>> tb/testbench.sv
// Self-checking bench for the interrupt controller
`timescale 1ns/1ps
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin bad_count++; \
   $display("unexpected at %0t: got %h exp %h", $time, (a), (e)); end end
module testbench
   import irq_pkg::*;
;
   logic                  clk_sys, rst, psel, penable, pwrite, ret_req, sleeping, err;
   logic       [7:0]      paddr;
   logic       [31:0]     pwdata, rd;
   logic       [1:0]      pin;
   logic       [14:0]     evt;
   wire logic  [31:0]     prdata;
   wire logic             pready, pslverr, pc_load, wake, return_from_service;
   wire logic  [PC_W-1:0] pc_value, pc_next;
   wire logic  [SP_W-1:0] stack_level;
   logic       [PC_W-1:0] p0, ld_pc;
   int                    bad_count = 0, checks = 0, loads = 0, wakes = 0;

   irq_controller i_irq_controller (.clk_sys(clk_sys), .rst(rst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .ext_request_pin_0(pin[0]),
      .ext_request_pin_1(pin[1]), .overvolt_evt(evt[0]), .undervolt_evt(evt[1]),
      .overcurrent_evt(evt[3:2]), .conv_done_evt(evt[4]), .tick_evt(evt[6:5]),
      .lowvolt_evt(evt[7]), .nvdata_evt(evt[8]), .timer_cmpa_evt(evt[11:9]),
      .timer_cmpp_evt(evt[14:12]), .pc_next(pc_next),
      .return_from_service(return_from_service), .sleeping(sleeping), .pc_load(pc_load),
      .pc_value(pc_value), .wake(wake), .stack_level(stack_level));
   core_model i_core_model (.clk_sys(clk_sys), .rst(rst), .pc_load(pc_load),
      .pc_value(pc_value), .ret_req(ret_req), .pc_next(pc_next),
      .return_from_service(return_from_service));

   initial begin
      clk_sys = 1'b0;
      forever #20 clk_sys = ~clk_sys;
   end
   // Address latched with its pulse, so back-to-back loads each stay checkable
   always @(posedge clk_sys) begin
      if (pc_load === 1'b1) begin
         loads <= loads + 1;
         ld_pc <= pc_value;
      end
      if (wake === 1'b1) wakes <= wakes + 1;
   end

   ////////////////////////////////////////////////////////////////////////////
   function automatic logic [PC_W-1:0] vec(input int i);
      return VEC_BASE + VEC_STEP * PC_W'(i);
   endfunction
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      do begin
         @(posedge clk_sys);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rchk(input logic [7:0] a, input logic [7:0] e);
      apb(1'b0, a, 32'h0);
      `CHK(rd, {24'h0, e})
   endtask
   task automatic pulse(input int b);
      @(posedge clk_sys);
      evt[b] <= 1'b1;
      @(posedge clk_sys);
      evt[b] <= 1'b0;
   endtask
   task automatic wait_load(input int k);
      for (int n = 0; n < 30 && loads < k; n++) @(posedge clk_sys);
      `CHK(loads, k)
   endtask
   task automatic ret();
      @(posedge clk_sys);
      ret_req <= 1'b1;
      @(posedge clk_sys);
      ret_req <= 1'b0;
   endtask
   task automatic do_reset();
      @(posedge clk_sys);
      rst <= 1'b1;
      repeat (2) @(posedge clk_sys);
      rst <= 1'b0;
      `CHK(stack_level, 3'h0)
   endtask
   task automatic finish_test();
      if (bad_count == 0 && checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////
   task automatic t_regs();
      logic [7:0] wv [8] = '{8'hff, 8'hfe, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff};
      logic [7:0] ev [8] = '{8'h0f, 8'h7e, 8'hff, 8'hff, 8'h33, 8'h33, 8'h33, 8'h77};
      for (int i = 0; i < 8; i++) rchk(8'(4 * i), 8'h00);
      apb(1'b0, 8'h20, 32'h0);
      `CHK(err, 1'b1)
      for (int i = 0; i < 8; i++) apb(1'b1, 8'(4 * i), {24'h0, wv[i]});
      for (int i = 0; i < 8; i++) rchk(8'(4 * i), ev[i]);
      for (int i = 0; i < 8; i++) apb(1'b1, 8'(4 * i), 32'h0);
   endtask
   // Each event with its enable off sets only its own flag
   task automatic t_events();
      logic [7:0] ra [15] = '{OFS_PROT, OFS_PINS, OFS_PROT, OFS_PROT, OFS_ADTB, OFS_TBLV,
         OFS_ADTB, OFS_TBLV, OFS_GRP2, OFS_GRP0, OFS_GRP1, OFS_GRP2, OFS_GRP0, OFS_GRP1,
         OFS_GRP2};
      logic [7:0] fv [15] = '{8'h40, 8'h10, 8'h10, 8'h20, 8'h20, 8'h80, 8'h10, 8'h40,
         8'h40, 8'h20, 8'h20, 8'h20, 8'h10, 8'h10, 8'h10};
      for (int i = 0; i < 15; i++) begin
         pulse(i);
         rchk(ra[i], fv[i]);
         apb(1'b1, ra[i], 32'h0);
      end
   endtask
   task automatic t_edges();
      for (int p = 0; p < 2; p++) begin
         for (int c = 0; c < 4; c++) begin
            apb(1'b1, OFS_EDGE, 32'(c << (2 * p)));
            pin[p] <= 1'b1;
            repeat (4) @(posedge clk_sys);
            rchk(OFS_PINS, 8'(c & 1) << (5 + p));
            apb(1'b1, OFS_PINS, 32'h0);
            pin[p] <= 1'b0;
            repeat (4) @(posedge clk_sys);
            rchk(OFS_PINS, 8'((c >> 1) & 1) << (5 + p));
            apb(1'b1, OFS_PINS, 32'h0);
         end
      end
   endtask
   task automatic t_vector();
      pulse(4);
      apb(1'b1, OFS_PROT, 32'h1);
      repeat (6) @(posedge clk_sys);
      `CHK(loads, 0)
      p0 = pc_next;
      apb(1'b1, OFS_ADTB, 32'h22);
      wait_load(1);
      `CHK(ld_pc, vec(9))
      `CHK(stack_level, 3'h1)
      rchk(OFS_PROT, 8'h00);
      pulse(4);
      rchk(OFS_ADTB, 8'h22);
      `CHK(loads, 1)
      ret();
      wait_load(2);
      `CHK(ld_pc, p0)
      wait_load(3);
      `CHK(ld_pc, vec(9))
      do_reset();
   endtask
   task automatic t_priority();
      pulse(1);
      pulse(3);
      apb(1'b1, OFS_PINS, 32'h11);
      apb(1'b1, OFS_PROT, 32'h25);
      wait_load(loads + 1);
      `CHK(ld_pc, vec(3))
      ret();
      wait_load(loads + 2);
      `CHK(ld_pc, vec(5))
      do_reset();
   endtask
   task automatic t_group();
      apb(1'b1, OFS_GRP0, 32'h2);
      pulse(9);
      rchk(OFS_PINS, 8'h80);
      apb(1'b1, OFS_PINS, 32'h88);
      apb(1'b1, OFS_PROT, 32'h1);
      wait_load(loads + 1);
      `CHK(ld_pc, vec(6))
      rchk(OFS_PINS, 8'h08);
      rchk(OFS_GRP0, 8'h22);
      do_reset();
   endtask
   task automatic t_stack();
      int l0;
      apb(1'b1, OFS_TBLV, 32'h4);
      for (int i = 0; i < 5; i++) begin
         l0 = loads;
         pulse(7);
         apb(1'b1, OFS_PROT, 32'h1);
         repeat (8) @(posedge clk_sys);
         `CHK(loads, l0 + (i < 4 ? 1 : 0))
      end
      `CHK(stack_level, 3'h4)
      ret();
      wait_load(loads + 2);
      `CHK(ld_pc, vec(12))
      do_reset();
   endtask
   task automatic t_wake();
      sleeping <= 1'b1;
      pulse(8);
      repeat (3) @(posedge clk_sys);
      `CHK(wakes, 1)
      pulse(8);
      repeat (3) @(posedge clk_sys);
      `CHK(wakes, 1)
      sleeping <= 1'b0;
   endtask

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      {rst, psel, penable, pwrite, ret_req, sleeping} = 6'b100000;
      {paddr, pwdata, pin, evt} = '0;
      repeat (2) @(posedge clk_sys);
      rst <= 1'b0;
      t_regs();
      t_events();
      t_edges();
      t_vector();
      t_priority();
      t_group();
      t_stack();
      t_wake();
      finish_test();
   end
   initial begin
      repeat (20000) @(posedge clk_sys);
      bad_count++;
      finish_test();
   end
endmodule
